// ### lsd_pkg.sv
/*
 lsd_pkg: constants, command codes and carrier types for the
 segment LCD driver command unit.
 Assumes nothing beyond a SystemVerilog compile of this file first.
*/
package lsd_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int DATA_W = 8;
   localparam logic [6:0] COL_LAST = 7'h4F;
   localparam logic [6:0] COL_STOP = 7'h50;
   localparam logic [8:0] RAM_COLS = 9'h050;
   localparam int RAM_BYTES = 320;

   // ----------------------------------------
   // command codes and decode masks
   // ----------------------------------------
   localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
   localparam logic [7:0] CMD_DISP_ON = 8'hAF;
   localparam logic [7:0] CMD_ADC_NORM = 8'hA0;
   localparam logic [7:0] CMD_ADC_INV = 8'hA1;
   localparam logic [7:0] CMD_STATIC_OFF = 8'hA4;
   localparam logic [7:0] CMD_STATIC_ON = 8'hA5;
   localparam logic [7:0] CMD_DUTY_THIRD = 8'hA8;
   localparam logic [7:0] CMD_DUTY_QUARTER = 8'hA9;
   localparam logic [7:0] CMD_RMW = 8'hE0;
   localparam logic [7:0] CMD_RMW_END = 8'hEE;
   localparam logic [7:0] CMD_SOFT_RESET = 8'hE2;
   localparam logic [7:0] START_MASK = 8'hE0;
   localparam logic [7:0] START_BASE = 8'hC0;
   localparam logic [7:0] PAGE_MASK = 8'hFC;
   localparam logic [7:0] PAGE_BASE = 8'hB8;

   // ----------------------------------------
   // status byte field positions
   // ----------------------------------------
   localparam int ST_BUSY_BIT = 7;
   localparam int ST_ADC_BIT = 6;
   localparam int ST_OFF_BIT = 5;
   localparam int ST_RST_BIT = 4;

   // ----------------------------------------
   // values after reset
   // ----------------------------------------
   localparam logic [4:0] RST_START = 5'h00;
   localparam logic [6:0] RST_COL = 7'h00;
   localparam logic [1:0] RST_PAGE = 2'h0;
   localparam logic RST_DISPLAY_ON = 1'b0;
   localparam logic RST_STATIC = 1'b0;
   localparam logic RST_DUTY_QUARTER = 1'b1;
   localparam logic RST_SEG_NORMAL = 1'b1;

   // ----------------------------------------
   // busy times in clock cycles
   // ----------------------------------------
   localparam logic [3:0] CMD_BUSY_CYCLES = 4'h2;
   localparam logic [3:0] RESET_BUSY_CYCLES = 4'h8;

   typedef enum logic [1:0] {
      LSD_IDLE = 2'b00,
      LSD_EXEC = 2'b01,
      LSD_RESET = 2'b10
   } lsd_state_t;

   typedef struct packed {
      logic reg_select;
      logic rd_n;
      logic wr_n;
      logic [7:0] data;
   } lsd_host_bus_t;

   typedef struct packed {
      logic display_on;
      logic static_drive;
      logic duty_quarter;
      logic seg_normal;
      logic power_save;
      logic [4:0] start_line;
   } lsd_drive_t;

   function automatic logic [8:0] lsd_ram_index(input logic [1:0] page,
                                                 input logic [6:0] col);
      return 9'(page) * RAM_COLS + 9'(col);
   endfunction : lsd_ram_index
endpackage : lsd_pkg

// ### lsd_dram.sv
/*
 lsd_dram: display RAM of 4 pages by 80 columns of bytes, one write
 port, a host read port and a scan read port, both combinational.
 Assumes callers keep columns below 80 for writes.
*/
`timescale 1ns/10ps
`default_nettype none
module lsd_dram
   import lsd_pkg::*;
(
   input wire logic clk_i,
   input wire logic wr_en_i,
   input wire logic [1:0] page_i,
   input wire logic [6:0] col_i,
   input wire logic [7:0] wr_data_i,
   output logic [7:0] rd_data_o,
   input wire logic [1:0] scan_page_i,
   input wire logic [6:0] scan_col_i,
   output logic [7:0] scan_data_o
);
   // contents are kept across every reset, so no reset here
   logic [7:0] mem [RAM_BYTES];

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[lsd_ram_index(page_i, col_i)] <= wr_data_i;
      end
   end

   // columns past the last one read as zero
   always_comb begin
      rd_data_o = 8'h00;
      scan_data_o = 8'h00;
      if (col_i < COL_STOP) begin
         rd_data_o = mem[lsd_ram_index(page_i, col_i)];
      end
      if (scan_col_i < COL_STOP) begin
         scan_data_o = mem[lsd_ram_index(scan_page_i, scan_col_i)];
      end
   end
endmodule : lsd_dram
`default_nettype wire

// ### lsd_command_unit.sv
/*
 lsd_command_unit: host command decoder, address counters, status
 and I/O latch of a segment LCD driver, plus scan-side address mapping.
 Assumes host strobes and data are synchronous to clk_i and that each
 strobe stays low at least two cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module lsd_command_unit
   import lsd_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic hw_reset_pin_n_i,
   input wire lsd_host_bus_t host_bus_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   input wire logic [1:0] scan_common_i,
   input wire logic [6:0] scan_seg_i,
   output logic scan_pixel_o,
   output logic [3:0] common_select_o,
   output var lsd_drive_t drive_o,
   output logic lcd_halt_o,
   output logic ext_clk_block_o
);
   // ----------------------------------------
   // declarations
   // ----------------------------------------
   lsd_state_t state;
   logic [3:0] busy_cnt;
   logic rd_prev;
   logic wr_prev;
   logic rd_take;
   logic wr_take;
   logic hw_rst;
   logic busy;
   logic resetting;
   logic cmd_take;
   logic dwr_take;
   logic drd_take;
   logic srd_take;
   logic [7:0] cmd;
   logic display_on;
   logic static_drive;
   logic duty_quarter;
   logic seg_normal;
   logic power_save;
   logic [4:0] start_line;
   logic [1:0] page;
   logic [6:0] col;
   logic rmw;
   logic [6:0] rmw_col;
   logic [7:0] io_latch;
   logic [7:0] ram_rd;
   logic [7:0] status;
   logic ram_wr_en;
   logic [4:0] scan_line;
   logic [6:0] scan_col;
   logic [7:0] scan_data;
   logic common_in_duty;

   // ----------------------------------------
   // column counter step
   // ----------------------------------------
   // saturates at the stop column so a long burst cannot wrap onto column 0
   function automatic logic [6:0] col_next(input logic [6:0] c);
      return (c < COL_STOP) ? c + 7'h01 : c;
   endfunction : col_next

   // ----------------------------------------
   // host strobe edges and transfer split
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_prev <= 1'b1;
         wr_prev <= 1'b1;
      end else begin
         rd_prev <= host_bus_i.rd_n;
         wr_prev <= host_bus_i.wr_n;
      end
   end

   // one transfer per strobe: only the falling edge counts
   assign rd_take = rd_prev & ~host_bus_i.rd_n;
   assign wr_take = wr_prev & ~host_bus_i.wr_n;
   assign hw_rst = ~hw_reset_pin_n_i;
   assign cmd = host_bus_i.data;
   assign cmd_take = wr_take & ~host_bus_i.reg_select & ~busy;
   assign dwr_take = wr_take & host_bus_i.reg_select & ~busy;
   assign drd_take = rd_take & host_bus_i.reg_select & ~busy;
   assign srd_take = rd_take & ~host_bus_i.reg_select;
   assign data_oe_o = ~host_bus_i.rd_n;

   // ----------------------------------------
   // busy sequencing
   // ----------------------------------------
   assign busy = (state != LSD_IDLE) | hw_rst;
   assign resetting = (state == LSD_RESET) | hw_rst;

   // a pin reset reloads the count on every cycle it is held, so busy
   // covers the whole pulse and then the full tail after it
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= LSD_IDLE;
         busy_cnt <= 4'h0;
      end else if (hw_rst) begin
         state <= LSD_RESET;
         busy_cnt <= RESET_BUSY_CYCLES;
      end else begin
         case (state)
            LSD_IDLE: begin
               if (cmd_take && cmd == CMD_SOFT_RESET) begin
                  state <= LSD_RESET;
                  busy_cnt <= RESET_BUSY_CYCLES;
               end else if (cmd_take) begin
                  state <= LSD_EXEC;
                  busy_cnt <= CMD_BUSY_CYCLES;
               end
            end
            LSD_EXEC, LSD_RESET: begin
               if (busy_cnt == 4'h1) begin
                  state <= LSD_IDLE;
                  busy_cnt <= 4'h0;
               end else begin
                  busy_cnt <= busy_cnt - 4'h1;
               end
            end
            default: begin
               state <= LSD_IDLE;
               busy_cnt <= 4'h0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // drive mode settings
   // ----------------------------------------
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         display_on <= RST_DISPLAY_ON;
         static_drive <= RST_STATIC;
         duty_quarter <= RST_DUTY_QUARTER;
         seg_normal <= RST_SEG_NORMAL;
      end else if (hw_rst) begin
         display_on <= RST_DISPLAY_ON;
         static_drive <= RST_STATIC;
         duty_quarter <= RST_DUTY_QUARTER;
         seg_normal <= RST_SEG_NORMAL;
      end else if (cmd_take) begin
         case (cmd)
            CMD_DISP_OFF, CMD_DISP_ON: begin
               display_on <= cmd[0];
            end
            CMD_ADC_NORM, CMD_ADC_INV: begin
               seg_normal <= ~cmd[0];
            end
            CMD_STATIC_OFF, CMD_STATIC_ON: begin
               static_drive <= cmd[0];
            end
            CMD_DUTY_THIRD, CMD_DUTY_QUARTER: begin
               duty_quarter <= cmd[0];
            end
            default: begin
               display_on <= display_on;
            end
         endcase
      end
   end

   // settings are held in power save; only the drive stops
   assign power_save = static_drive & ~display_on;
   // the clock gate shares the halt term so both stop in the same cycle
   assign lcd_halt_o = power_save;
   assign ext_clk_block_o = power_save;

   // ----------------------------------------
   // start line, page and column registers
   // ----------------------------------------
   // a column set inside read-modify-write is taken as written; the end
   // command still returns to the column saved on entry
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         start_line <= RST_START;
         page <= RST_PAGE;
         col <= RST_COL;
         rmw <= 1'b0;
         rmw_col <= RST_COL;
      end else if (hw_rst) begin
         start_line <= RST_START;
         page <= RST_PAGE;
         col <= RST_COL;
         rmw <= 1'b0;
         rmw_col <= RST_COL;
      end else if (cmd_take) begin
         if ((cmd & START_MASK) == START_BASE) begin
            start_line <= cmd[4:0];
         end else if ((cmd & PAGE_MASK) == PAGE_BASE) begin
            page <= cmd[1:0];
         end else if (!cmd[7]) begin
            col <= cmd[6:0];
         end else if (cmd == CMD_RMW) begin
            rmw <= 1'b1;
            rmw_col <= col;
         end else if (cmd == CMD_RMW_END) begin
            rmw <= 1'b0;
            if (rmw) begin
               col <= rmw_col;
            end
         end else if (cmd == CMD_SOFT_RESET) begin
            start_line <= RST_START;
            page <= RST_PAGE;
            col <= RST_COL;
         end
      end else if (dwr_take) begin
         col <= col_next(col);
      end else if (drd_take && !rmw) begin
         col <= col_next(col);
      end
   end

   // ----------------------------------------
   // display RAM
   // ----------------------------------------
   // writes at the stop column are dropped, there is no cell there
   assign ram_wr_en = dwr_take & (col < COL_STOP);

   lsd_dram u_dram (
      .clk_i(clk_i),
      .wr_en_i(ram_wr_en),
      .page_i(page),
      .col_i(col),
      .wr_data_i(host_bus_i.data),
      .rd_data_o(ram_rd),
      .scan_page_i(scan_line[4:3]),
      .scan_col_i(scan_col),
      .scan_data_o(scan_data)
   );

   // ----------------------------------------
   // read path: status and pipelined data latch
   // ----------------------------------------
   always_comb begin
      status = 8'h00;
      status[ST_BUSY_BIT] = busy;
      status[ST_ADC_BIT] = seg_normal;
      status[ST_OFF_BIT] = ~display_on;
      status[ST_RST_BIT] = resetting;
   end

   // the latch holds the byte fetched by the previous read, hence the
   // dummy read the host owes after moving the column
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         io_latch <= 8'h00;
      end else if (drd_take) begin
         io_latch <= ram_rd;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         data_o <= 8'h00;
         // status reads are never refused, so busy can be polled at any time
      end else if (srd_take) begin
         data_o <= status;
      end else if (drd_take) begin
         data_o <= io_latch;
      end
   end

   // ----------------------------------------
   // scan side mapping
   // ----------------------------------------
   // five-bit sum wraps past line 31 on its own
   assign scan_line = start_line + {3'b000, scan_common_i};
   assign scan_col = seg_normal ? scan_seg_i : COL_LAST - scan_seg_i;
   // third duty leaves the fourth common dark outside static drive, and its pixels blank
   assign common_in_duty = duty_quarter | (scan_common_i != 2'h3);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         scan_pixel_o <= 1'b0;
      end else if (power_save || !(display_on || static_drive)) begin
         scan_pixel_o <= 1'b0;
      end else begin
         scan_pixel_o <= scan_data[scan_line[2:0]] & common_in_duty;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         common_select_o <= 4'h0;
      end else if (power_save) begin
         common_select_o <= 4'h0;
      end else if (static_drive) begin
         common_select_o <= 4'hF;
      end else if (display_on && common_in_duty) begin
         common_select_o <= 4'h1 << scan_common_i;
      end else begin
         common_select_o <= 4'h0;
      end
   end

   // ----------------------------------------
   // drive state to the waveform side
   // ----------------------------------------
   always_comb begin
      drive_o.display_on = display_on;
      drive_o.static_drive = static_drive;
      drive_o.duty_quarter = duty_quarter;
      drive_o.seg_normal = seg_normal;
      drive_o.power_save = power_save;
      drive_o.start_line = start_line;
   end
endmodule : lsd_command_unit
`default_nettype wire

// ### lsd_checker_assertions.sv
/* lsd_checker_assertions: port checks for lsd_command_unit.
 Assumes one clock domain and a bind onto the design's top module. */
`timescale 1ns/10ps
`default_nettype none
module lsd_chk
   import lsd_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic hw_reset_pin_n_i,
   input wire lsd_host_bus_t host_bus_i,
   input wire logic [7:0] data_o,
   input wire logic data_oe_o,
   input wire logic scan_pixel_o,
   input wire lsd_drive_t drive_o,
   input wire logic lcd_halt_o,
   input wire logic ext_clk_block_o
);
   logic wr_q, rd_q, cmd_ok, st_take;
   logic [3:0] busy;
   logic [7:0] d;
   assign d = host_bus_i.data;
   assign cmd_ok = !host_bus_i.wr_n && wr_q && !host_bus_i.reg_select && busy == 4'h0
      && hw_reset_pin_n_i;
   assign st_take = !host_bus_i.rd_n && rd_q && !host_bus_i.reg_select;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_q <= 1'b1;
         rd_q <= 1'b1;
      end else begin
         wr_q <= host_bus_i.wr_n;
         rd_q <= host_bus_i.rd_n;
      end
   end
   // shadow of the busy time, so refused commands are not expected to act
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy <= 4'h0;
      end else if (!hw_reset_pin_n_i || (cmd_ok && d == CMD_SOFT_RESET)) begin
         busy <= RESET_BUSY_CYCLES;
      end else if (cmd_ok) begin
         busy <= CMD_BUSY_CYCLES;
      end else if (busy != 4'h0) begin
         busy <= busy - 4'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_disp_on_cmd: assert property (cmd_ok && d == CMD_DISP_ON |=> drive_o.display_on)
      else $error("display stays off");
   a_disp_off_cmd: assert property (cmd_ok && d == CMD_DISP_OFF |=> !drive_o.display_on)
      else $error("display stays on");
   a_start_load: assert property ((cmd_ok && (d & START_MASK) == START_BASE)
      |=> drive_o.start_line == $past(d[4:0])) else $error("start line wrong");
   a_seg_map_sel: assert property (cmd_ok && d[7:1] == 7'h50
      |=> drive_o.seg_normal == !$past(d[0])) else $error("segment map wrong");
   a_static_sel: assert property (cmd_ok && d[7:1] == 7'h52
      |=> drive_o.static_drive == $past(d[0])) else $error("static drive wrong");
   a_duty_sel: assert property (cmd_ok && d[7:1] == 7'h54
      |=> drive_o.duty_quarter == $past(d[0])) else $error("duty wrong");
   a_halt_state: assert property (lcd_halt_o == (drive_o.static_drive && !drive_o.display_on)
      && ext_clk_block_o == lcd_halt_o && drive_o.power_save == lcd_halt_o)
      else $error("power save state wrong");
   a_halt_blanks: assert property (lcd_halt_o |=> !scan_pixel_o)
      else $error("pixel driven in power save");
   a_oe_follows_rd: assert property (data_oe_o == !host_bus_i.rd_n)
      else $error("output enable wrong");
   a_status_fields: assert property (st_take |=> data_o[3:0] == 4'h0
      && data_o[5] == !drive_o.display_on && data_o[6] == drive_o.seg_normal)
      else $error("status fields wrong");
   a_status_busy: assert property (st_take && busy != 4'h0 |=> data_o[7])
      else $error("busy not shown");
   c_rmw: cover property (cmd_ok && d == CMD_RMW);
   c_halt: cover property (lcd_halt_o);
   c_busy_read: cover property (st_take && busy != 4'h0);
endmodule : lsd_chk
bind lsd_command_unit lsd_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .hw_reset_pin_n_i(hw_reset_pin_n_i), .host_bus_i(host_bus_i), .data_o(data_o),
   .data_oe_o(data_oe_o), .scan_pixel_o(scan_pixel_o), .drive_o(drive_o),
   .lcd_halt_o(lcd_halt_o), .ext_clk_block_o(ext_clk_block_o));
`default_nettype wire

// ### lsd_host_model.sv
/* lsd_host_model: host processor on the 8-bit parallel bus.
 Assumes its task is called from one sequence synchronous to clk_i. */
`timescale 1ns/10ps
`default_nettype none
module lsd_host_model
   import lsd_pkg::*;
(
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output var lsd_host_bus_t bus_o
);
   initial bus_o = 11'h300;
   // ----------------------------------------
   // one transfer: strobe low two edges, high one
   // ----------------------------------------
   task automatic xfer(input logic rs, input logic rd, input logic [7:0] dv,
                       output logic [7:0] q);
      @(posedge clk_i);
      bus_o <= {rs, !rd, rd, dv};
      repeat (2) @(posedge clk_i);
      q = rdata_i;
      // released lines do not keep the last value
      bus_o <= {rs, 2'b11, ~dv};
      @(posedge clk_i);
   endtask : xfer
endmodule : lsd_host_model
`default_nettype wire

// ### tb_lsd_command_unit.sv
/* tb_lsd_command_unit: self-checking bench for lsd_command_unit.
 Assumes the host model and checker are compiled alongside. */
`timescale 1ns/10ps
`default_nettype none
module tb_lsd_command_unit
   import lsd_pkg::*;
;
   logic clk_i, sys_rst_i, rst_n, pix, halt;
   logic [1:0] scom;
   logic [6:0] sseg;
   logic [3:0] csel;
   logic [7:0] data_o, q;
   lsd_host_bus_t bus;
   lsd_drive_t drv;
   int err_total, compares, cyc;
   lsd_command_unit u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hw_reset_pin_n_i(rst_n),
      .host_bus_i(bus), .data_o(data_o), .data_oe_o(), .scan_common_i(scom),
      .scan_seg_i(sseg), .scan_pixel_o(pix), .common_select_o(csel), .drive_o(drv),
      .lcd_halt_o(halt), .ext_clk_block_o());
   lsd_host_model u_host (.clk_i(clk_i), .rdata_i(data_o), .bus_o(bus));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic cmd(input logic [7:0] c);
      u_host.xfer(1'b0, 1'b0, c, q);
      repeat (2) @(posedge clk_i);
   endtask : cmd
   task automatic wd(input logic [7:0] v);
      u_host.xfer(1'b1, 1'b0, v, q);
   endtask : wd
   task automatic dummy();
      u_host.xfer(1'b1, 1'b1, 8'h00, q);
   endtask : dummy
   task automatic rdd(input string n, input logic [7:0] e);
      u_host.xfer(1'b1, 1'b1, 8'h00, q);
      chk(n, e, q);
   endtask : rdd
   task automatic st(input logic [7:0] e);
      u_host.xfer(1'b0, 1'b1, 8'h00, q);
      chk("status", e, q);
   endtask : st
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_hw_reset();
      st(8'hF0);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk_i);
      st(8'h60);
   endtask : t_hw_reset
   task automatic t_data();
      cmd(8'hB9);
      cmd(8'h4E);
      wd(8'hA1);
      wd(8'hA2);
      wd(8'hA3);
      cmd(8'h4E);
      dummy();
      rdd("col 78", 8'hA1);
      rdd("col 79", 8'hA2);
      rdd("col 80", 8'h00);
   endtask : t_data
   task automatic t_rmw();
      cmd(8'h0A);
      wd(8'h11);
      wd(8'h22);
      cmd(8'h0A);
      cmd(CMD_RMW);
      dummy();
      rdd("rmw hold", 8'h11);
      wd(8'h33);
      dummy();
      rdd("rmw write step", 8'h22);
      cmd(CMD_RMW_END);
      dummy();
      rdd("rmw restore", 8'h33);
   endtask : t_rmw
   task automatic t_modes();
      cmd(CMD_ADC_INV);
      st(8'h20);
      cmd(CMD_ADC_NORM);
      cmd(CMD_DUTY_THIRD);
      cmd(CMD_DUTY_QUARTER);
      cmd(CMD_STATIC_ON);
      chk("halt", 8'h01, 8'(halt));
      chk("common save", 8'h00, 8'(csel));
      cmd(CMD_DISP_ON);
      chk("halt", 8'h00, 8'(halt));
      chk("common static", 8'h0F, 8'(csel));
      st(8'h40);
      cmd(CMD_DISP_OFF);
      chk("halt", 8'h01, 8'(halt));
      cmd(CMD_STATIC_OFF);
      chk("halt", 8'h00, 8'(halt));
   endtask : t_modes
   task automatic t_soft_reset();
      cmd(8'hBA);
      cmd(8'h05);
      wd(8'h5A);
      cmd(8'hC5);
      chk("start", 8'h05, 8'(drv.start_line));
      u_host.xfer(1'b0, 1'b0, CMD_SOFT_RESET, q);
      st(8'hF0);
      u_host.xfer(1'b0, 1'b0, CMD_DISP_ON, q);
      repeat (8) @(posedge clk_i);
      chk("refused on", 8'h00, 8'(drv.display_on));
      chk("start", 8'h00, 8'(drv.start_line));
      wd(8'h77);
      cmd(8'hBA);
      cmd(8'h05);
      dummy();
      rdd("ram kept", 8'h5A);
      cmd(8'hB8);
      cmd(8'h00);
      dummy();
      rdd("page 0", 8'h77);
   endtask : t_soft_reset
   task automatic t_scan();
      cmd(CMD_DISP_ON);
      cmd(8'hDE);
      scom <= 2'h2;
      sseg <= 7'h00;
      repeat (2) @(posedge clk_i);
      chk("pixel wrap", 8'h01, 8'(pix));
      chk("common select", 8'h04, 8'(csel));
      cmd(CMD_ADC_INV);
      sseg <= 7'h4F;
      repeat (2) @(posedge clk_i);
      chk("pixel inverted", 8'h01, 8'(pix));
      scom <= 2'h3;
      repeat (2) @(posedge clk_i);
      chk("quarter common 3", 8'h08, 8'(csel));
      chk("quarter pixel", 8'h01, 8'(pix));
      cmd(CMD_DUTY_THIRD);
      chk("third common 3", 8'h00, 8'(csel));
      chk("third pixel", 8'h00, 8'(pix));
   endtask : t_scan
   task automatic complete_run();
      $display("mismatches %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      sys_rst_i = 1'b1;
      rst_n = 1'b0;
      scom = 2'h0;
      sseg = 7'h00;
      err_total = 0;
      compares = 0;
      cyc = 0;
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      t_hw_reset();
      t_data();
      t_rmw();
      t_modes();
      t_soft_reset();
      t_scan();
      complete_run();
   end
   // cut a hang short well beyond the few hundred cycles the run needs
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
endmodule : tb_lsd_command_unit
`default_nettype wire
